// ==== hdl/idle_clock_pkg.sv ====
package idle_clock_pkg;

  // Register map
  localparam logic [31:0] IDLE_ENTRY_CTRL1_ADDR = 32'hfffece04;
  localparam logic [31:0] IDLE_ENTRY_CTRL1_RST = 32'h0000_00cc;

  // Field positions in mpu_idle_entry_ctrl1
  localparam int PERIPH_IDLE_GATE_BIT = 0;
  localparam int DMA_ACTIVITY_MODE_BIT = 1;
  localparam int DISPLAY_CLK_EN_BIT = 2;
  localparam int HOST_PORT_CLK_EN_BIT = 3;
  localparam int PLL_IDLE_PERMIT_BIT = 4;
  localparam int PERIPH_IDLE_CLK_EN_BIT = 6;
  localparam int PERIPH_REF_CLK_EN_BIT = 7;
  localparam int CORE_SLEEP_REQUEST_BIT = 11;
  localparam logic [31:0] CTRL1_WRITABLE_MASK = 32'h0000_08df;

  // Timing: sleep request latency and least acknowledge time
  localparam int SYS_CLK_MHZ = 25;
  localparam int REF_CLK_MHZ = 12;
  localparam int REQ_REF_CYCLES = 4;
  localparam int REQ_CORE_CYCLES = 2;
  localparam int ACK_MIN_CORE_CYCLES = 3;
  localparam int REQ_LAT_CYCLES =
    (REQ_REF_CYCLES * SYS_CLK_MHZ + REF_CLK_MHZ - 1) / REF_CLK_MHZ
    + REQ_CORE_CYCLES;
  localparam logic [3:0] REQ_LAT_CNT = 4'(REQ_LAT_CYCLES);
  localparam logic [3:0] ACK_MIN_CNT = 4'(ACK_MIN_CORE_CYCLES);

  typedef enum logic [1:0] {
    CORE_RUN,
    CORE_REQ_DELAY,
    CORE_REQ_WAIT_ACK,
    CORE_ASLEEP
  } core_state_t;

  // Activity and status coming from the rest of the chip
  typedef struct packed {
    logic core_irq;
    logic dsp_irq;
    logic dsp_global_idle;
    logic dsp_pll_idle;
    logic dma_req;
    logic dma_active;
    logic local_bus_active;
    logic post_write_queued;
    logic mem_txn_done;
    logic sdram_self_refresh;
    logic pll_out_clk_a_stoppable;
    logic pll_out_clk_b_stoppable;
    logic pll_out_clk_c_stoppable;
  } activity_t;

  // Clock gate enables, high = clock runs
  typedef struct packed {
    logic core_clk;
    logic sys_dma_clk;
    logic traffic_ctrl_clk;
    logic sdram_clk_gate;
    logic periph_bridge_clk;
    logic display_clk;
    logic host_port_clk;
    logic periph_idle_clk;
    logic periph_ref_clk;
  } clk_gates_t;

endpackage

// ==== hdl/mpu_tc_idle_clock_gating.sv ====
`timescale 1ns/1ps
`default_nettype none

// How it works
// (R1) Acknowledge after wait-for-interrupt stops the core clock, no request.
// (R2) Wait-for-interrupt path needs no delay; acknowledge alone enters idle.
// (R3) A core interrupt wakes the sleeping core and restarts its clock; a DSP interrupt does not.
// (R4) Writing bit 11 of the control register raises a sleep request.
// (R5) Request reaches core after four reference plus two core cycles.
// (R6) Acknowledge accepted only three or more cycles after request issued.
// (R7) Software must stall six read strobes before idling; core does not check that.
// (R8) Processor PLL idles when all its clock users are stopped.
// (R9) PLL idle needs permit, DSP idle, core idle, no traffic, no interrupt.
// (R10) Peripherals get an idle-gated and a reference clock, both enabled.
// (R11) DMA clock runs on transfer activity or stops only at core idle.
// (R12) Traffic clock stops when both PLLs idle, no DMA, memory done.
// (R13) SDRAM clock gate off only in self-refresh with no local bus.
// (R14) Bridge clock stops when core idle and no DMA transfer.
// (R15) Display clock follows traffic idle and its own enable bit.
// (R16) Host port clock is stopped only by its enable bit.
// (R17) Software finishes transfers and stops domains before traffic idle.
// (R18) Traffic clock restarts on interrupt, DMA request or bus activity.
// (R19) With permit set, PLL idles only when no output clock is in use and the R9 conditions hold.
// (R20) Stoppable indications from each clock generator decide PLL idle.
// (R21) Core clock restarts on enabled interrupt or on reset.
// (R22) Request holds until wake; core clock gated only after acknowledge.
module mpu_tc_idle_clock_gating (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  input wire logic core_sleep_ack_i,
  input wire idle_clock_pkg::activity_t act_i,
  output logic core_sleep_req_o,
  output logic processor_pll_idle_o,
  output logic traffic_ctrl_idle_o,
  output var idle_clock_pkg::clk_gates_t gates_o
);
  import idle_clock_pkg::*;

  logic rst_sync1_ff;
  logic rst_sync2_ff;
  logic rst_n;
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  core_state_t state_ff;
  core_state_t nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic req_ff;
  logic pll_idle_ff;
  logic tc_idle_ff;
  logic [31:0] rdata_ff;
  logic hit;
  logic wr_hit;
  logic wake;
  logic core_idle;
  logic periph_idle_clk;
  logic tc_wake;
  logic pll_can_idle;
  logic tc_can_idle;
  logic core_clk_on_ff;
  logic dma_clk_on_ff;
  logic tc_clk_on_ff;
  logic sdram_clk_on_ff;
  logic bridge_clk_on_ff;
  logic display_clk_on_ff;
  logic host_clk_on_ff;
  logic periph_idle_on_ff;
  logic periph_ref_on_ff;

  // One step of the sleep sequencing counters
  function automatic logic [3:0] count_up(input logic [3:0] value);
    count_up = value + 4'h1;
  endfunction

  // Clocks that stop with the core run unless it is asleep next
  function automatic logic runs_after(input core_state_t state);
    runs_after = (state != CORE_ASLEEP);
  endfunction

  // Reset release synchroniser
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end
  assign rst_n = rst_sync2_ff;

  assign hit = reg_sel_i && (reg_addr_i == IDLE_ENTRY_CTRL1_ADDR);
  assign wr_hit = hit && reg_wr_i;
  assign wake = act_i.core_irq; // (R3) (R21)
  assign core_idle = (state_ff == CORE_ASLEEP);

  // Control register; hardware clears the request bit on wake from sleep,
  // a software set in the same cycle wins over that clear
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wake && core_idle) begin
      nxt_ctrl[CORE_SLEEP_REQUEST_BIT] = 1'b0;
    end
    if (wr_hit) begin
      nxt_ctrl = reg_wdata_i & CTRL1_WRITABLE_MASK; // (R4)
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= IDLE_ENTRY_CTRL1_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Read path; unmapped addresses read as zero
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (hit && !reg_wr_i) begin
      rdata_ff <= ctrl_ff;
    end else if (reg_sel_i && !reg_wr_i) begin
      rdata_ff <= 32'h0000_0000;
    end
  end
  assign reg_rdata_o = rdata_ff;

  // Core sleep sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      CORE_RUN: begin
        nxt_cnt = 4'h0;
        if (core_sleep_ack_i && !wake) begin
          nxt_state = CORE_ASLEEP; // (R1) (R2)
        end else if (ctrl_ff[CORE_SLEEP_REQUEST_BIT]) begin
          nxt_state = CORE_REQ_DELAY; // (R4)
        end
      end
      CORE_REQ_DELAY: begin
        nxt_cnt = count_up(cnt_ff);
        if (!ctrl_ff[CORE_SLEEP_REQUEST_BIT]) begin
          nxt_state = CORE_RUN;
        end else if (cnt_ff == REQ_LAT_CNT - 4'h1) begin
          nxt_state = CORE_REQ_WAIT_ACK; // (R5)
          nxt_cnt = 4'h0;
        end
      end
      CORE_REQ_WAIT_ACK: begin
        if (cnt_ff != ACK_MIN_CNT) begin
          nxt_cnt = count_up(cnt_ff);
        end
        if (wake) begin
          nxt_state = CORE_RUN;
        end else if (core_sleep_ack_i && cnt_ff == ACK_MIN_CNT) begin
          nxt_state = CORE_ASLEEP; // (R6) (R22)
        end
      end
      CORE_ASLEEP: begin
        if (wake) begin
          nxt_state = CORE_RUN; // (R3) (R21)
        end
      end
      default: begin
        nxt_state = CORE_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= CORE_RUN;
      cnt_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // Request stays up from the end of the latency until wake
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      req_ff <= 1'b0;
    end else begin
      req_ff <= (nxt_state == CORE_REQ_WAIT_ACK)
                || (nxt_state == CORE_ASLEEP
                    && ctrl_ff[CORE_SLEEP_REQUEST_BIT]); // (R22)
    end
  end
  assign core_sleep_req_o = req_ff;

  // Idle-gated peripheral clock
  assign periph_idle_clk = ctrl_ff[PERIPH_IDLE_CLK_EN_BIT]
    && !(core_idle && ctrl_ff[PERIPH_IDLE_GATE_BIT]); // (R10)

  // Processor PLL idle decision
  assign pll_can_idle = ctrl_ff[PLL_IDLE_PERMIT_BIT] // (R19)
    && act_i.dsp_global_idle
    && core_idle
    && !act_i.dma_active
    && !act_i.local_bus_active
    && !act_i.post_write_queued
    && !periph_idle_clk
    && !act_i.core_irq
    && !act_i.dsp_irq // (R9)
    && act_i.pll_out_clk_a_stoppable
    && act_i.pll_out_clk_b_stoppable
    && act_i.pll_out_clk_c_stoppable; // (R20) (R8)

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pll_idle_ff <= 1'b0;
    end else begin
      pll_idle_ff <= pll_can_idle; // (R9)
    end
  end
  assign processor_pll_idle_o = pll_idle_ff;

  // Traffic controller idle; wake takes priority over entry
  assign tc_wake = act_i.core_irq || act_i.dsp_irq
    || act_i.dma_req || act_i.local_bus_active // (R18)
    || act_i.dma_active; // (R12)
  assign tc_can_idle = pll_idle_ff && act_i.dsp_pll_idle
    && !act_i.dma_active && act_i.mem_txn_done // (R12)
    && act_i.sdram_self_refresh && !act_i.local_bus_active; // (R13)

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tc_idle_ff <= 1'b0;
    end else if (tc_wake) begin
      tc_idle_ff <= 1'b0; // (R18)
    end else if (tc_can_idle) begin
      tc_idle_ff <= 1'b1; // (R12)
    end
  end
  assign traffic_ctrl_idle_o = tc_idle_ff;

  // Core clock stops as the asleep state is entered
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      core_clk_on_ff <= 1'b0;
    end else begin
      core_clk_on_ff <= runs_after(nxt_state); // (R22) (R21)
    end
  end

  // DMA clock follows transfers, or stops only with the core
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dma_clk_on_ff <= 1'b0;
    end else if (ctrl_ff[DMA_ACTIVITY_MODE_BIT]) begin
      dma_clk_on_ff <= act_i.dma_active || act_i.dma_req; // (R11)
    end else begin
      dma_clk_on_ff <= runs_after(nxt_state); // (R11)
    end
  end

  // Traffic and SDRAM clocks stop together with traffic idle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tc_clk_on_ff <= 1'b0;
    end else begin
      tc_clk_on_ff <= !tc_idle_ff; // (R12)
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sdram_clk_on_ff <= 1'b0;
    end else begin
      sdram_clk_on_ff <= !tc_idle_ff; // (R13)
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bridge_clk_on_ff <= 1'b0;
    end else begin
      bridge_clk_on_ff <= !(core_idle && !act_i.dma_active); // (R14)
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      display_clk_on_ff <= 1'b0;
    end else begin
      display_clk_on_ff <= ctrl_ff[DISPLAY_CLK_EN_BIT]
        && !tc_idle_ff; // (R15)
    end
  end

  // Host port clock obeys only its enable bit
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      host_clk_on_ff <= 1'b0;
    end else begin
      host_clk_on_ff <= ctrl_ff[HOST_PORT_CLK_EN_BIT]; // (R16)
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      periph_idle_on_ff <= 1'b0;
    end else begin
      periph_idle_on_ff <= periph_idle_clk; // (R10)
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      periph_ref_on_ff <= 1'b0;
    end else begin
      periph_ref_on_ff <= ctrl_ff[PERIPH_REF_CLK_EN_BIT]; // (R10)
    end
  end

  // Gate bundle driven straight from the flip-flops above
  always_comb begin
    gates_o.core_clk = core_clk_on_ff;
    gates_o.sys_dma_clk = dma_clk_on_ff;
    gates_o.traffic_ctrl_clk = tc_clk_on_ff;
    gates_o.sdram_clk_gate = sdram_clk_on_ff;
    gates_o.periph_bridge_clk = bridge_clk_on_ff;
    gates_o.display_clk = display_clk_on_ff;
    gates_o.host_port_clk = host_clk_on_ff;
    gates_o.periph_idle_clk = periph_idle_on_ff;
    gates_o.periph_ref_clk = periph_ref_on_ff;
  end

endmodule

`default_nettype wire

// ==== test/core_sleep_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Core side of the sleep handshake: acknowledge stays up until a wake
module core_sleep_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic wfi_i,
  input wire logic irq_i,
  output logic ack_o
);
  import idle_clock_pkg::*;
  logic [3:0] cnt_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 4'h0;
      ack_o <= 1'b0;
    end else if (irq_i) begin
      cnt_ff <= 4'h0;
      ack_o <= 1'b0;
    end else if (wfi_i) begin
      ack_o <= 1'b1;
    end else if (req_i && !ack_o) begin
      cnt_ff <= cnt_ff + 4'h1;
      ack_o <= (cnt_ff + 4'h1 >= ACK_MIN_CNT);
    end
  end
endmodule
`default_nettype wire

// ==== test/mpu_tc_idle_clock_gating_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module mpu_tc_idle_clock_gating_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic core_sleep_ack_i,
  input wire idle_clock_pkg::activity_t act_i,
  input wire logic core_sleep_req_o,
  input wire logic processor_pll_idle_o,
  input wire idle_clock_pkg::clk_gates_t gates_o
);
  import idle_clock_pkg::*;
  logic [2:0] up_ff;
  logic wr;
  assign wr = reg_sel_i && reg_wr_i && reg_addr_i == IDLE_ENTRY_CTRL1_ADDR;
  // Checks wait until the gates have left their reset values
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_ff <= 3'h0;
    end else if (up_ff != 3'h7) begin
      up_ff <= up_ff + 3'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i || up_ff != 3'h7);
  sequence req_late;
    !core_sleep_req_o [*8] ##1 !core_sleep_req_o [*3]
      ##[1:3] core_sleep_req_o;
  endsequence
  sequence busy_2;
    (act_i.dma_active || act_i.dma_req || act_i.dsp_irq
      || act_i.local_bus_active) [*2];
  endsequence
  AST_REQ_LATENCY: assert property (
    wr && reg_wdata_i[11] && !core_sleep_req_o && !act_i.core_irq
    |=> req_late) else $error("sleep request latency wrong");
  AST_REQ_HOLD: assert property (
    core_sleep_req_o && !act_i.core_irq && !wr |=> core_sleep_req_o)
    else $error("sleep request dropped without wake");
  AST_ACK_MIN: assert property (
    $rose(core_sleep_req_o) |-> gates_o.core_clk [*3])
    else $error("core clock stopped too early");
  AST_GATE_AFTER_ACK: assert property (
    $fell(gates_o.core_clk) |-> $past(core_sleep_ack_i))
    else $error("core clock stopped without acknowledge");
  AST_WAKE: assert property (
    act_i.core_irq && !gates_o.core_clk |-> ##[1:2] gates_o.core_clk)
    else $error("core clock did not restart");
  AST_HOST_SW_ONLY: assert property (
    $changed(gates_o.host_port_clk) |-> $past(wr, 2))
    else $error("host port clock moved without write");
  AST_DISPLAY_OFF: assert property (
    wr && !reg_wdata_i[2] |-> ##2 !gates_o.display_clk)
    else $error("display clock not forced off");
  AST_TC_RESTART: assert property (
    busy_2 |=> gates_o.traffic_ctrl_clk)
    else $error("traffic clock stopped while busy");
  AST_BRIDGE_DMA: assert property (
    act_i.dma_active [*2] |=> gates_o.periph_bridge_clk)
    else $error("bridge clock stopped during transfer");
  AST_PLL_COND: assert property (
    processor_pll_idle_o |-> $past(act_i.dsp_global_idle
      && !act_i.dma_active && !act_i.local_bus_active
      && !act_i.post_write_queued && !act_i.core_irq))
    else $error("pll idle with activity present");
endmodule
bind mpu_tc_idle_clock_gating mpu_tc_idle_clock_gating_chk chk_inst (
  .clk_i, .rst_n_i, .reg_sel_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
  .core_sleep_ack_i, .act_i, .core_sleep_req_o, .processor_pll_idle_o,
  .gates_o);
`default_nettype wire

// ==== test/mpu_tc_idle_clock_gating_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module mpu_tc_idle_clock_gating_test;
  import idle_clock_pkg::*;
  localparam logic [31:0] A = IDLE_ENTRY_CTRL1_ADDR;
  logic clk_i, rst_n_i, sel, wr, ack, wfi, req, pll, tci;
  logic [31:0] addr, wdata, rdata, q;
  logic [4:0] obs;
  activity_t act;
  clk_gates_t g;
  int mismatches, n_compared, n;
  assign obs = {g.traffic_ctrl_clk, g.core_clk, req, pll,
                g.periph_bridge_clk};
  mpu_tc_idle_clock_gating mpu_tc_idle_clock_gating_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_sel_i(sel), .reg_wr_i(wr),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .core_sleep_ack_i(ack), .act_i(act), .core_sleep_req_o(req),
    .processor_pll_idle_o(pll), .traffic_ctrl_idle_o(tci), .gates_o(g));
  core_sleep_model core_sleep_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .req_i(req), .wfi_i(wfi), .irq_i(act.core_irq), .ack_o(ack));
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    sel = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    @(posedge clk_i) #1;
    sel = 1'b0;
    @(posedge clk_i) #1;
    q = rdata;
  endtask
  task automatic wait_on(input int i, input logic v);
    n = 0;
    while (obs[i] !== v) begin
      @(posedge clk_i) #1;
      n++;
      if (n > 300) begin
        mismatches++;
        $display("BAD wait %0d", i);
        stop_test();
      end
    end
  endtask
  task automatic wake;
    act.core_irq = 1'b1;
    @(posedge clk_i) #1;
    act.core_irq = 1'b0;
    wait_on(3, 1'b1);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    {rst_n_i, sel, wr, wfi} = 4'h0;
    {addr, wdata, act} = '0;
    repeat (16) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 bus(0, A, 0);
    cmp("reset", IDLE_ENTRY_CTRL1_RST, q);
    cmp("ref clk", 1, g.periph_ref_clk);
    bus(1, A ^ 32'h10, 32'h0);
    bus(0, A ^ 32'h10, 0);
    cmp("unmapped", 0, q);
    bus(1, A, 32'hffff_f7ff);
    bus(0, A, 0);
    cmp("mask", 32'h0000_00df, q);
    bus(1, A, 32'h0000_00c8);
    cmp("display off", 0, g.display_clk);
    bus(1, A, 32'h0000_00c4);
    cmp("host off", 0, g.host_port_clk);
    cmp("display on", 1, g.display_clk);
    bus(1, A, 32'h0000_08cc);
    // No register access until the core is asleep
    wait_on(2, 1'b1);
    cmp("req late", 1, n + 1 >= REQ_LAT_CYCLES);
    wait_on(3, 1'b0);
    cmp("ack gap", 1, n >= ACK_MIN_CORE_CYCLES);
    cmp("req held", 1, req);
    wake();
    cmp("req clear", 0, req);
    bus(0, A, 0);
    cmp("bit clear", 0, q[CORE_SLEEP_REQUEST_BIT]);
    wfi = 1'b1;
    @(posedge clk_i) #1;
    wfi = 1'b0;
    wait_on(3, 1'b0);
    wait_on(0, 1'b0);
    cmp("dma clk idle", 0, g.sys_dma_clk);
    act.dma_active = 1'b1;
    repeat (3) @(posedge clk_i);
    #1 cmp("bridge on", 1, g.periph_bridge_clk);
    cmp("tc on", 1, g.traffic_ctrl_clk);
    act = 13'h0;
    // Transfers done and domains off before traffic idle
    bus(1, A, 32'h0000_0053);
    act = 13'h061f;
    wait_on(1, 1'b1);
    wait_on(4, 1'b0);
    cmp("tc idle", 1, tci);
    cmp("sdram off", 0, g.sdram_clk_gate);
    cmp("periph gated", 0, g.periph_idle_clk);
    cmp("ref clk off", 0, g.periph_ref_clk);
    act.post_write_queued = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 cmp("pll busy", 0, pll);
    act.post_write_queued = 1'b0;
    wait_on(1, 1'b1);
    act.local_bus_active = 1'b1;
    repeat (3) @(posedge clk_i);
    #1 cmp("tc restart", 1, g.traffic_ctrl_clk);
    cmp("tc awake", 0, tci);
    act = 13'h071f;
    repeat (2) @(posedge clk_i);
    #1 cmp("dma clk run", 1, g.sys_dma_clk);
    wake();
    @(posedge clk_i) #1;
    cmp("periph clk run", 1, g.periph_idle_clk);
    stop_test();
  end
endmodule
`default_nettype wire
